// >>> ett_top.sv
`timescale 1ns/1ps
`default_nettype none
module ett_top
    import ett_pkg::*;
(
    input wire logic mclk,              // system clock, 200 MHz
    input wire logic resetn,            // async reset, low
    input wire ett_pkg::ett_bus_t bus,  // cpu register access
    output logic [7:0] rdata,           // read data, one cycle after rd
    input wire logic ext_count_in_b,    // external count pin for b
    input wire logic ext_count_in_c,    // external count pin for c
    output logic timer_out_a,           // timer output a
    output logic timer_out_b,           // timer output b
    output logic timer_out_c,           // timer output c
    output logic match_irq_a,           // request a, one-cycle pulse
    output logic match_irq_b,           // request b, one-cycle pulse
    output logic match_irq_c            // request c, also wide counter clock
);
    import ett_pkg::*;

    // pick a count pulse from the selected source
    function automatic logic sel_tick(input logic [1:0] sel, input logic pre,
                                      input logic alt, input logic alt2);
        logic r;
        r = 1'b1;
        unique case (sel)
            CLK_SYS: r = 1'b1;
            CLK_PRE: r = pre;
            CLK_ALT: r = alt;
            CLK_ALT2: r = alt2;
        endcase
        return r;
    endfunction : sel_tick

    logic [7:0] cmp_a, cmp_b, cmp_c, hw_b, hw_c;
    logic [7:0] ctl_a, ctl_b, ctl_c;
    logic [2:0] carr;
    logic [2:0] pre;
    logic [1:0] sync1, sync2, sync3;
    logic ph_b, ph_c, out_b_q;
    ett_chan_t st_a, st_b, st_c;

    // control fields
    wire run_a = ctl_a[B_RUN];
    wire run_b = ctl_b[B_RUN];
    wire run_c = ctl_c[B_RUN];
    wire both_edge_sel_a = ctl_a[B_EDGE];
    wire out_en_a = ctl_a[B_OUT_EN];
    wire out_en_b = ctl_b[B_OUT_EN];
    wire out_en_c = ctl_c[B_OUT_EN];
    wire [1:0] mode_a = {ctl_a[B_MODE_HI], ctl_a[B_MODE_LO]};
    wire [1:0] mode_b = {ctl_b[B_MODE_HI], ctl_b[B_MODE_LO]};
    wire standalone_sel_c = ctl_c[B_MODE_LO];
    wire [1:0] clk_a = {ctl_a[B_CLK_HI], ctl_a[B_CLK_LO]};
    wire [1:0] clk_b = {ctl_b[B_CLK_HI], ctl_b[B_CLK_LO]};
    wire [1:0] clk_c = {ctl_c[B_CLK_HI], ctl_c[B_CLK_LO]};
    wire rmc = carr[B_RMC];
    wire nrz = carr[B_NRZ];
    wire nrz_buf = carr[B_NRZ_BUF];

    // mode decode; unlisted combinations fall back to stand-alone behaviour
    wire casc = (mode_a == MD_CASC) && (mode_b == MD_CASC);
    wire carrier = (mode_a == MD_PLAIN) && (mode_b == MD_CARR);
    wire pwm = (mode_a == MD_SHAPE);
    wire ppg_b = (mode_b == MD_SHAPE) && !casc;
    wire ppg_c = standalone_sel_c;
    wire shape_b = ppg_b || carrier;
    // prescaler: rising pulse at wrap, half pulse gives the second edge
    wire pre_rise = (pre == PRE_LAST);
    wire pre_fall = (pre == PRE_HALF);
    wire pre_a = pre_rise || (pwm && both_edge_sel_a && pre_fall);
    // pin edges read only from the second and third sync stages
    wire [1:0] pin_rise = sync2 & ~sync3;
    wire out_b_rise = timer_out_b && !out_b_q;
    // count pulses; cascade drives a from b's clock and b from a's carry
    wire src_b = sel_tick(clk_b, pre_rise, pin_rise[0], pin_rise[0]);
    wire src_c = sel_tick(clk_c, pre_rise, pin_rise[1], pin_rise[1]);
    wire src_a = sel_tick(clk_a, pre_a, match_irq_b, out_b_rise);
    wire run_eff_a = casc ? run_b : run_a;
    wire tick_a = run_eff_a && (casc ? src_b : src_a);
    wire tick_b = run_b && (casc ? (tick_a && st_a.full) : src_b);
    wire tick_c = run_c && src_c;
    // match events
    wire ev_a = tick_a && st_a.eq;
    wire ev16 = casc && tick_a && st_a.eq && st_b.eq;
    wire ev_b = tick_b && (shape_b ? (ph_b ? st_b.eq_h : st_b.eq) : st_b.eq);
    wire ev_c = tick_c && (ppg_c ? (ph_c ? st_c.eq_h : st_c.eq) : st_c.eq);

    // clear terms; pwm free-runs through its compare
    wire clr_a = !run_eff_a || (casc ? ev16 : (!pwm && ev_a));
    wire clr_b = !run_b || (casc ? ev16 : ev_b);
    wire clr_c = !run_c || ev_c;

    ett_chan u_a (
        .mclk(mclk),
        .resetn(resetn),
        .tick(tick_a),
        .clr(clr_a),
        .cmp(cmp_a),
        .hcmp(cmp_a),
        .st(st_a)
    );
    ett_chan u_b (
        .mclk(mclk),
        .resetn(resetn),
        .tick(tick_b),
        .clr(clr_b),
        .cmp(cmp_b),
        .hcmp(hw_b),
        .st(st_b)
    );
    ett_chan u_c (
        .mclk(mclk),
        .resetn(resetn),
        .tick(tick_c),
        .clr(clr_c),
        .cmp(cmp_c),
        .hcmp(hw_c),
        .st(st_c)
    );
    // register decode
    wire wr_cmp_a = bus.wr && (bus.addr == OFS_CMP_A);
    wire wr_cmp_b = bus.wr && (bus.addr == OFS_CMP_B);
    wire wr_cmp_c = bus.wr && (bus.addr == OFS_CMP_C);
    wire wr_hw_b = bus.wr && (bus.addr == OFS_HW_B);
    wire wr_hw_c = bus.wr && (bus.addr == OFS_HW_C);
    wire wr_ctl_a = bus.wr && (bus.addr == OFS_CTL_A);
    wire wr_ctl_b = bus.wr && (bus.addr == OFS_CTL_B);
    wire wr_ctl_c = bus.wr && (bus.addr == OFS_CTL_C);
    wire wr_carr = bus.wr && (bus.addr == OFS_CARR);

    // read mux; counters are read-only, unmapped offsets read 00
    logic [7:0] next_rdata;
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (bus.addr)
            OFS_CMP_A: next_rdata = cmp_a;
            OFS_CMP_B: next_rdata = cmp_b;
            OFS_CMP_C: next_rdata = cmp_c;
            OFS_HW_B: next_rdata = hw_b;
            OFS_HW_C: next_rdata = hw_c;
            OFS_CNT_A: next_rdata = st_a.count;
            OFS_CNT_B: next_rdata = st_b.count;
            OFS_CNT_C: next_rdata = st_c.count;
            OFS_CTL_A: next_rdata = ctl_a;
            OFS_CTL_B: next_rdata = ctl_b;
            OFS_CTL_C: next_rdata = ctl_c;
            OFS_CARR: next_rdata = {5'h00, carr};
            default: next_rdata = 8'h00;
        endcase
    end

    // compare registers carry no reset: their value is undefined until written
    always_ff @(posedge mclk)
    begin
        if (wr_cmp_a) cmp_a <= bus.wdata;
        if (wr_cmp_b) cmp_b <= bus.wdata;
        if (wr_cmp_c) cmp_c <= bus.wdata;
        if (wr_hw_b) hw_b <= bus.wdata;
        if (wr_hw_c) hw_c <= bus.wdata;
    end

    // control registers and read data
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctl_a <= CTL_RESET;
            ctl_b <= CTL_RESET;
            ctl_c <= CTL_RESET;
            rdata <= 8'h00;
        end
        else
        begin
            if (wr_ctl_a) ctl_a <= bus.wdata;
            if (wr_ctl_b) ctl_b <= {bus.wdata[7], 1'b0, bus.wdata[5:0]};
            if (wr_ctl_c) ctl_c <= {bus.wdata[7], 1'b0, bus.wdata[5:0]};
            if (bus.rd) rdata <= next_rdata;
        end
    end

    // carrier data: next level loads on a's match, writes reach it only while b's output is disabled
    wire next_nrz = (carrier && ev_a) ? nrz_buf : ((wr_carr && !out_en_b) ? bus.wdata[0] : nrz);
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            carr <= 3'h0;
        else
        begin
            carr[B_NRZ] <= next_nrz;
            if (wr_carr) carr[2:1] <= bus.wdata[2:1];
        end
    end

    // prescaler and pin synchronisers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pre <= 3'h0;
            sync1 <= 2'h0;
            sync2 <= 2'h0;
            sync3 <= 2'h0;
        end
        else
        begin
            pre <= pre + 3'h1;
            sync1 <= {ext_count_in_c, ext_count_in_b};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // phases: 1 = high width running against the high-width compare
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ph_b <= 1'b0;
            ph_c <= 1'b0;
        end
        else
        begin
            if (!run_b || !shape_b) ph_b <= 1'b0;
            else if (ev_b) ph_b <= !ph_b;
            if (!run_c || !ppg_c) ph_c <= 1'b0;
            else if (ev_c) ph_c <= !ph_c;
        end
    end

    // output stage; a is disabled in cascade and b then carries the 16-bit wave
    logic next_out_a, next_out_b, next_out_c;
    always_comb
    begin
        next_out_a = timer_out_a;
        if (!out_en_a || casc)
            next_out_a = 1'b0;
        else if (pwm)
            next_out_a = run_a && (st_a.count < cmp_a);
        else if (ev_a)
            next_out_a = !timer_out_a;
        next_out_b = timer_out_b;
        if (!out_en_b)
            next_out_b = 1'b0;
        else if (carrier)
            next_out_b = nrz && (rmc || ph_b);
        else if (ppg_b)
            next_out_b = ph_b;
        else if (casc ? ev16 : ev_b)
            next_out_b = !timer_out_b;
        next_out_c = timer_out_c;
        if (!out_en_c)
            next_out_c = 1'b0;
        else if (ppg_c)
            next_out_c = ph_c;
        else if (ev_c)
            next_out_c = !timer_out_c;
    end

    // outputs and match requests from flip-flops
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            timer_out_a <= 1'b0;
            timer_out_b <= 1'b0;
            timer_out_c <= 1'b0;
            out_b_q <= 1'b0;
            match_irq_a <= 1'b0;
            match_irq_b <= 1'b0;
            match_irq_c <= 1'b0;
        end
        else
        begin
            timer_out_a <= next_out_a;
            timer_out_b <= next_out_b;
            timer_out_c <= next_out_c;
            out_b_q <= timer_out_b;
            match_irq_a <= ev_a && !casc;
            match_irq_b <= casc ? ev16 : ev_b;
            match_irq_c <= ev_c;
        end
    end

    // checks
    sequence s_match_a;
        tick_a && st_a.eq && !casc;
    endsequence
    property p_irq_a;
        @(posedge mclk) disable iff (!resetn) s_match_a |=> match_irq_a;
    endproperty
    a_irq_a: assert property (p_irq_a) else $error("request a missing on match");
    property p_casc_no_a;
        @(posedge mclk) disable iff (!resetn) (casc && $past(casc)) |-> !match_irq_a;
    endproperty
    a_casc_no_a: assert property (p_casc_no_a) else $error("request a in cascade");
    property p_casc_irq_b;
        @(posedge mclk) disable iff (!resetn)
            ev16 |=> match_irq_b && st_a.count == 8'h00 && st_b.count == 8'h00;
    endproperty
    a_casc_irq_b: assert property (p_casc_irq_b) else $error("joint match mishandled");
    property p_stop_a;
        @(posedge mclk) disable iff (!resetn) (!casc && !run_a) |=> st_a.count == 8'h00;
    endproperty
    a_stop_a: assert property (p_stop_a) else $error("stopped a not cleared");
    property p_casc_stop;
        @(posedge mclk) disable iff (!resetn)
            (casc && !run_b) [*2] |-> st_a.count == 8'h00 && st_b.count == 8'h00;
    endproperty
    a_casc_stop: assert property (p_casc_stop) else $error("cascade not cleared");
    // counter a must advance in cascade even with its own run bit clear
    property p_run_a_ignored;
        @(posedge mclk) disable iff (!resetn)
            (casc && !run_a && tick_a && !ev16) |=> st_a.count == $past(st_a.count) + 8'h01;
    endproperty
    a_run_a_ignored: assert property (p_run_a_ignored) else $error("cascade a stalled");
    property p_square;
        @(posedge mclk) disable iff (!resetn)
            (s_match_a and (out_en_a && !pwm)) |=> timer_out_a != $past(timer_out_a);
    endproperty
    a_square: assert property (p_square) else $error("output a did not toggle");
    property p_shape_clear;
        @(posedge mclk) disable iff (!resetn)
            (shape_b && !casc && tick_b && ph_b && st_b.eq_h) |=> st_b.count == 8'h00 && !ph_b;
    endproperty
    a_shape_clear: assert property (p_shape_clear) else $error("b high width end missed");
    property p_nrz_load;
        @(posedge mclk) disable iff (!resetn) (carrier && ev_a) |=> nrz == $past(nrz_buf);
    endproperty
    a_nrz_load: assert property (p_nrz_load) else $error("carrier data not loaded");
    property p_pwm_free;
        @(posedge mclk) disable iff (!resetn)
            (pwm && run_a && tick_a && st_a.eq && !st_a.full) |=> st_a.count == $past(cmp_a) + 8'h01;
    endproperty
    a_pwm_free: assert property (p_pwm_free) else $error("pwm counter cleared on match");
endmodule : ett_top
`default_nettype wire

// >>> ett_pkg.sv
// Function
// - mode bits pick stand-alone, cascade, carrier, PWM, PPG or 24-bit use per channel
// - channels b and c also count external pin events in stand-alone mode
// - cascade joins counters a and b into one 16-bit counter
// - carrier clock from b is gated onto b's output, period set by a
// - PWM on a: free-running period, compare a sets the high width
// - PPG: programmable period and width, compare c sets c's low width
// - carrier and PPG: high-width compare sets the channel's high width
// - 24-bit use of c only counts; wide counter is clocked by c's request
// - counter a equal to compare a raises request a, except in cascade
// - cascade: request b only on simultaneous match of both, request a never
// - high-width compare match also raises that channel's request
// - counters read 00 after reset, compare registers are left unreset
// - counters are read-only bytes, compare registers are written as bytes
// - stand-alone counter clears on reset, run clear, match and overflow
// - cascade counters clear together on reset, run_b clear, joint match, overflow
// - three 8-bit counters, five 8-bit compares, three timer outputs
// - cascade counting follows run_b only, run_a is ignored
// - carrier and PPG counters also clear on the high-width match
`default_nettype none
package ett_pkg;
    localparam int W = 8;
    localparam int AW = 4;
    // register byte offsets
    localparam logic [3:0] OFS_CMP_A = 4'h0;
    localparam logic [3:0] OFS_CMP_B = 4'h1;
    localparam logic [3:0] OFS_CMP_C = 4'h2;
    localparam logic [3:0] OFS_HW_B = 4'h3;
    localparam logic [3:0] OFS_HW_C = 4'h4;
    localparam logic [3:0] OFS_CNT_A = 4'h5;
    localparam logic [3:0] OFS_CNT_B = 4'h6;
    localparam logic [3:0] OFS_CNT_C = 4'h7;
    localparam logic [3:0] OFS_CTL_A = 4'h8;
    localparam logic [3:0] OFS_CTL_B = 4'h9;
    localparam logic [3:0] OFS_CTL_C = 4'ha;
    localparam logic [3:0] OFS_CARR = 4'hb;
    // control field positions
    localparam int B_RUN = 7;
    localparam int B_EDGE = 6;
    localparam int B_CLK_HI = 5;
    localparam int B_CLK_LO = 4;
    localparam int B_MODE_HI = 2;
    localparam int B_MODE_LO = 1;
    localparam int B_OUT_EN = 0;
    localparam int B_RMC = 2;
    localparam int B_NRZ_BUF = 1;
    localparam int B_NRZ = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_FULL = 8'hff;
    // count clock choices
    localparam logic [1:0] CLK_SYS = 2'h0;
    localparam logic [1:0] CLK_PRE = 2'h1;
    localparam logic [1:0] CLK_ALT = 2'h2;
    localparam logic [1:0] CLK_ALT2 = 2'h3;
    // mode codes of the a/b mode fields
    localparam logic [1:0] MD_PLAIN = 2'h0;
    localparam logic [1:0] MD_CASC = 2'h1;
    localparam logic [1:0] MD_SHAPE = 2'h2;
    localparam logic [1:0] MD_CARR = 2'h3;
    localparam logic [2:0] PRE_LAST = 3'h7;
    localparam logic [2:0] PRE_HALF = 3'h3;

    typedef struct packed {
        logic [W-1:0] count;
        logic eq;
        logic eq_h;
        logic full;
    } ett_chan_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic wr;
        logic rd;
        logic [W-1:0] wdata;
    } ett_bus_t;
endpackage : ett_pkg
`default_nettype wire

// >>> ett_chan.sv
`timescale 1ns/1ps
`default_nettype none
module ett_chan
    import ett_pkg::*;
(
    input wire logic mclk,              // system clock
    input wire logic resetn,            // async reset, low
    input wire logic tick,              // count enable pulse
    input wire logic clr,               // synchronous clear
    input wire logic [7:0] cmp,         // compare value
    input wire logic [7:0] hcmp,        // high-width compare value
    output ett_pkg::ett_chan_t st       // count and compare flags
);
    import ett_pkg::*;

    logic [7:0] count;
    logic [7:0] next_count;

    // clear beats counting; ff+1 wraps to 00 which is the overflow clear
    assign next_count = clr ? CNT_RESET : (tick ? count + 8'h01 : count);
    assign st.count = count;
    assign st.eq = (count == cmp);
    assign st.eq_h = (count == hcmp);
    assign st.full = (count == CNT_FULL);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            count <= CNT_RESET;
        else
            count <= next_count;
    end
endmodule : ett_chan
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ett_pkg::*;

    logic mclk;
    logic resetn;
    ett_pkg::ett_bus_t bus;
    logic [7:0] rdata;
    logic ext_b;
    logic ext_c;
    logic out_a;
    logic out_b;
    logic out_c;
    logic irq_a;
    logic irq_b;
    logic irq_c;
    int err_count;
    int checks;
    // per-window tallies filled by measure
    int hi_a, hi_b, hi_c, n_a, n_b, n_c;
    logic [7:0] rd_val;

    ett_top DUT (
        .mclk(mclk),
        .resetn(resetn),
        .bus(bus),
        .rdata(rdata),
        .ext_count_in_b(ext_b),
        .ext_count_in_c(ext_c),
        .timer_out_a(out_a),
        .timer_out_b(out_b),
        .timer_out_c(out_c),
        .match_irq_a(irq_a),
        .match_irq_b(irq_b),
        .match_irq_c(irq_c)
    );

    // 200 MHz
    always #2.5 mclk = ~mclk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done();
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // strobes go up and down on falling edges, so the rising edge sees them steady
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk);
        bus.addr = a;
        bus.wdata = d;
        bus.wr = 1'b1;
        @(negedge mclk);
        bus.wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(negedge mclk);
        bus.addr = a;
        bus.rd = 1'b1;
        @(negedge mclk);
        bus.rd = 1'b0;
        rd_val = rdata;
    endtask : rd

    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
        rd(a);
        check(name, rd_val, exp);
    endtask : rd_chk

    // falling-edge sampling sees each one-cycle request exactly once
    task automatic measure(input int n);
        hi_a = 0;
        hi_b = 0;
        hi_c = 0;
        n_a = 0;
        n_b = 0;
        n_c = 0;
        repeat (n)
        begin
            @(negedge mclk);
            hi_a += int'(out_a === 1'b1);
            hi_b += int'(out_b === 1'b1);
            hi_c += int'(out_c === 1'b1);
            n_a += int'(irq_a === 1'b1);
            n_b += int'(irq_b === 1'b1);
            n_c += int'(irq_c === 1'b1);
        end
    endtask : measure

    // four cycles per edge leaves room for the three-cycle pin latency
    task automatic pins(input int n, input bit to_c);
        repeat (n)
        begin
            @(negedge mclk);
            if (to_c) ext_c = 1'b1; else ext_b = 1'b1;
            repeat (2) @(negedge mclk);
            if (to_c) ext_c = 1'b0; else ext_b = 1'b0;
            @(negedge mclk);
        end
        repeat (6) @(negedge mclk);
    endtask : pins

    task automatic stop_all();
        wr(OFS_CTL_A, 8'h00);
        wr(OFS_CTL_B, 8'h00);
        wr(OFS_CTL_C, 8'h00);
        repeat (4) @(negedge mclk);
    endtask : stop_all

    // watchdog: the sequence needs about 3800 cycles
    initial
    begin
        #200us;
        err_count++;
        test_done();
    end

    initial
    begin
        mclk = 1'b0;
        resetn = 1'b0;
        bus = '0;
        ext_b = 1'b0;
        ext_c = 1'b0;
        err_count = 0;
        checks = 0;
        repeat (10) @(negedge mclk);
        resetn = 1'b1;
        // counters after reset, unmapped and read-only offsets
        rd_chk("counter_a", OFS_CNT_A, 8'h00);
        rd_chk("counter_b", OFS_CNT_B, 8'h00);
        rd_chk("counter_c", OFS_CNT_C, 8'h00);
        rd_chk("unmapped", 4'hf, 8'h00);
        wr(OFS_CNT_A, 8'h33);
        rd_chk("counter_a ro", OFS_CNT_A, 8'h00);
        // five byte-wide compare registers hold what was written
        for (int i = 0; i < 5; i++)
            wr(4'(i), 8'h5a + 8'(i));
        for (int i = 0; i < 5; i++)
            rd_chk("compare", 4'(i), 8'h5a + 8'(i));
        // stand-alone a: match every 5 ticks, output toggles on each match
        wr(OFS_CMP_A, 8'h04);
        wr(OFS_CTL_A, 8'h81);
        repeat (20) @(negedge mclk);
        measure(100);
        check("irq_a count", n_a, 20);
        check("out_a high", hi_a, 50);
        wr(OFS_CTL_A, 8'h01);
        rd_chk("counter_a stop", OFS_CNT_A, 8'h00);
        stop_all();
        // a clocked by b's requests: b matches every 2 cycles, a every 10
        wr(OFS_CMP_B, 8'h01);
        wr(OFS_CTL_B, 8'h80);
        wr(OFS_CTL_A, 8'ha1);
        repeat (20) @(negedge mclk);
        measure(100);
        check("a on b requests", n_a, 10);
        check("a on b toggles", hi_a, 50);
        check("b match rate", n_b, 50);
        stop_all();
        // stand-alone b counting pin events, then cleared by run bit
        wr(OFS_CMP_B, 8'hff);
        wr(OFS_CTL_B, 8'ha0);
        pins(5, 1'b0);
        rd_chk("counter_b events", OFS_CNT_B, 8'h05);
        wr(OFS_CTL_B, 8'h20);
        rd_chk("counter_b stop", OFS_CNT_B, 8'h00);
        // cascade: joint match every 260 ticks, run_a left clear, b's output toggles
        wr(OFS_CMP_A, 8'h03);
        wr(OFS_CMP_B, 8'h01);
        wr(OFS_CTL_A, 8'h02);
        wr(OFS_CTL_B, 8'h83);
        repeat (20) @(negedge mclk);
        measure(520);
        check("cascade irq_b", n_b, 2);
        check("cascade irq_a", n_a, 0);
        check("cascade out_a", hi_a, 0);
        check("cascade out_b", hi_b, 260);
        wr(OFS_CTL_B, 8'h02);
        rd_chk("cascade counter_a", OFS_CNT_A, 8'h00);
        stop_all();
        // pwm on a: 256-cycle period, high for compare_a cycles; compare set while stopped
        wr(OFS_CMP_A, 8'h40);
        wr(OFS_CTL_A, 8'h85);
        repeat (20) @(negedge mclk);
        measure(256);
        check("pwm high", hi_a, 32'h40);
        stop_all();
        // both-edge pwm on the prescaler: a tick every 4 cycles, same duty
        wr(OFS_CTL_A, 8'hd5);
        repeat (20) @(negedge mclk);
        measure(1024);
        check("pwm both edges", hi_a, 256);
        stop_all();
        // ppg on c: low 4 ticks, high 6 ticks, two requests per period
        wr(OFS_CMP_C, 8'h03);
        wr(OFS_HW_C, 8'h05);
        wr(OFS_CTL_C, 8'h83);
        repeat (20) @(negedge mclk);
        measure(100);
        check("ppg high", hi_c, 60);
        check("ppg irq_c", n_c, 20);
        stop_all();
        // ppg on b from the prescaler: low 2 ticks, high 3 ticks, 8 cycles a tick
        wr(OFS_CMP_B, 8'h01);
        wr(OFS_HW_B, 8'h02);
        wr(OFS_CTL_B, 8'h95);
        repeat (20) @(negedge mclk);
        measure(80);
        check("ppg b high", hi_b, 48);
        check("ppg b irq", n_b, 4);
        stop_all();
        // carrier: nrz must be loaded before out_en_b locks it
        wr(OFS_CARR, 8'h07);
        wr(OFS_CMP_A, 8'h09);
        wr(OFS_CMP_B, 8'h01);
        wr(OFS_HW_B, 8'h01);
        wr(OFS_CTL_A, 8'h80);
        wr(OFS_CTL_B, 8'h87);
        repeat (20) @(negedge mclk);
        measure(40);
        check("carrier level", hi_b, 40);
        wr(OFS_CARR, 8'h04);
        repeat (20) @(negedge mclk);
        measure(40);
        check("carrier off", hi_b, 0);
        wr(OFS_CARR, 8'h02);
        repeat (20) @(negedge mclk);
        measure(40);
        check("carrier pulses", hi_b, 20);
        stop_all();
        // 24-bit use of c: one request per 256 pin edges
        wr(OFS_CMP_C, 8'hff);
        wr(OFS_CTL_C, 8'ha0);
        fork
            pins(255, 1'b1);
            measure(1030);
        join
        check("c 255 edges", n_c, 0);
        rd_chk("counter_c full", OFS_CNT_C, 8'hff);
        fork
            pins(1, 1'b1);
            measure(10);
        join
        check("c wrap irq", n_c, 1);
        rd_chk("counter_c wrap", OFS_CNT_C, 8'h00);
        stop_all();
        test_done();
    end
endmodule : tb_top
`default_nettype wire
